//--- rtl/fdcic_core.sv
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fdcic_core #(
  parameter logic [16:0] MS_TICK = fdcic_pkg::MS_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drives
  input wire logic [3:0] drive_ready,
  input wire logic [3:0] track0,
  input wire logic [7:0] drive_status,
  output logic step_out,
  output logic head_load,
  // host
  output logic irq
);
  typedef enum logic [1:0] {
    FDCIC_IDLE = 2'b00,
    FDCIC_EXEC = 2'b01,
    FDCIC_RESULT = 2'b10
  } fdcic_phase_t;

  fdcic_phase_t phase_ff;
  logic [15:0] timer_ff;
  logic [7:0] st0_ff;
  logic [7:0] result_ff;
  logic [4:0] cmd_ff;
  logic [3:0] busy_ff;
  logic [3:0] ready_q_ff;
  logic [3:0] ready_chg_ff;
  logic seek_pend_ff;
  logic seek_bad_ff;
  logic data_irq_ff;
  logic [16:0] ms_cnt_ff;
  logic [7:0] ms_left_ff;
  logic [7:0] steps_ff;
  logic [1:0] seek_drv_ff;
  logic seek_recal_ff;
  logic [7:0] xfer_left_ff;

  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire cmd_wr = wr && paddr == fdcic_pkg::ADDR_CMD;
  wire data_acc = psel && penable && paddr == fdcic_pkg::ADDR_DATA;
  wire tick = ms_cnt_ff == MS_TICK;
  wire pio = timer_ff[fdcic_pkg::TMR_PIO_BIT];
  wire [4:0] new_cmd = pwdata[4:0];
  wire [1:0] new_drv = pwdata[9:8];

  function automatic logic is_xfer(input logic [4:0] c);
    is_xfer = c == fdcic_pkg::CMD_READ || c == fdcic_pkg::CMD_READ_DEL ||
      c == fdcic_pkg::CMD_WRITE || c == fdcic_pkg::CMD_WRITE_DEL ||
      c == fdcic_pkg::CMD_READ_TRK || c == fdcic_pkg::CMD_READ_ID ||
      c == fdcic_pkg::CMD_FORMAT || c == fdcic_pkg::CMD_SCAN_EQ ||
      c == fdcic_pkg::CMD_SCAN_LE || c == fdcic_pkg::CMD_SCAN_HE;
  endfunction

  // reload is one short of the interval: the step fires on the tick after zero
  function automatic logic [7:0] step_reload(input logic [3:0] code);
    step_reload = 8'h0F - {4'h0, code};
  endfunction

  // unserviced seek or ready interrupt forces the next command, unless it is sense interrupt, to be undefined
  wire force_inv = (seek_pend_ff || |ready_chg_ff) && new_cmd != fdcic_pkg::CMD_SENSE_INT;
  wire known = is_xfer(new_cmd) || new_cmd == fdcic_pkg::CMD_SPECIFY ||
    new_cmd == fdcic_pkg::CMD_SENSE_DRV || new_cmd == fdcic_pkg::CMD_SENSE_INT ||
    new_cmd == fdcic_pkg::CMD_SEEK || new_cmd == fdcic_pkg::CMD_RECAL;
  wire accept = cmd_wr && phase_ff == FDCIC_IDLE;
  wire is_inv = accept && (!known || force_inv);
  wire xfer_done = phase_ff == FDCIC_EXEC && ms_left_ff == 8'h00 && tick &&
    (!pio || xfer_left_ff == 8'h00);
  wire seek_done = seek_pend_ff == 1'b0 && |busy_ff && tick && ms_left_ff == 8'h00 &&
    (track0[seek_drv_ff] || steps_ff == 8'h00);

  // millisecond prescaler; nominal ms taken at the core clock rate
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_ff <= 17'h00000;
    end else begin
      ms_cnt_ff <= tick ? 17'h00000 : ms_cnt_ff + 17'h00001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= fdcic_pkg::TMR_RESET;
    end else if (wr && paddr == fdcic_pkg::ADDR_TIMER) begin
      timer_ff <= pwdata[15:0];
    end else if (accept && !is_inv && new_cmd == fdcic_pkg::CMD_SPECIFY) begin
      timer_ff <= pwdata[31:16];
    end
  end

  // delay counter shared by settle, step and unload intervals
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_left_ff <= 8'h00;
    end else if (accept && !is_inv && is_xfer(new_cmd)) begin
      ms_left_ff <= 8'(timer_ff[fdcic_pkg::TMR_HLT_LSB +: 7] *
        fdcic_pkg::MS_PER_STEP_HLT);
    end else if (accept && !is_inv &&
                 (new_cmd == fdcic_pkg::CMD_SEEK || new_cmd == fdcic_pkg::CMD_RECAL)) begin
      ms_left_ff <= step_reload(timer_ff[fdcic_pkg::TMR_SRT_LSB +: 4]);
    end else if (xfer_done) begin
      ms_left_ff <= 8'(timer_ff[fdcic_pkg::TMR_HUT_LSB +: 4] *
        fdcic_pkg::MS_PER_STEP_HUT);
    end else if (tick && ms_left_ff != 8'h00) begin
      ms_left_ff <= ms_left_ff - 8'h01;
    end else if (tick && |busy_ff && !seek_done) begin
      ms_left_ff <= step_reload(timer_ff[fdcic_pkg::TMR_SRT_LSB +: 4]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_load <= 1'b0;
    end else if (accept && !is_inv && is_xfer(new_cmd)) begin
      head_load <= 1'b1;
    end else if (phase_ff != FDCIC_EXEC && tick && ms_left_ff == 8'h01) begin
      head_load <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= FDCIC_IDLE;
      cmd_ff <= 5'h00;
      xfer_left_ff <= 8'h00;
    end else begin
      unique case (phase_ff)
        FDCIC_IDLE: begin
          if (accept) begin
            cmd_ff <= new_cmd;
            xfer_left_ff <= pwdata[23:16];
            if (is_inv || new_cmd == fdcic_pkg::CMD_SENSE_INT ||
                new_cmd == fdcic_pkg::CMD_SENSE_DRV) begin
              phase_ff <= FDCIC_RESULT;
            end else if (is_xfer(new_cmd)) begin
              phase_ff <= FDCIC_EXEC;
            end
          end
        end
        FDCIC_EXEC: begin
          if (pio && data_acc && xfer_left_ff != 8'h00) begin
            xfer_left_ff <= xfer_left_ff - 8'h01;
          end
          if (xfer_done) begin
            phase_ff <= FDCIC_RESULT;
          end
        end
        FDCIC_RESULT: begin
          if (rd && paddr == fdcic_pkg::ADDR_DATA) begin
            phase_ff <= FDCIC_IDLE;
          end
        end
        default: phase_ff <= FDCIC_IDLE;
      endcase
    end
  end

  // seek engine: one drive steps at a time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 4'h0;
      seek_drv_ff <= 2'b00;
      steps_ff <= 8'h00;
      seek_pend_ff <= 1'b0;
      seek_bad_ff <= 1'b0;
      seek_recal_ff <= 1'b0;
      step_out <= 1'b0;
    end else begin
      step_out <= 1'b0;
      if (accept && !is_inv &&
          (new_cmd == fdcic_pkg::CMD_SEEK || new_cmd == fdcic_pkg::CMD_RECAL)) begin
        busy_ff[new_drv] <= 1'b1;
        seek_drv_ff <= new_drv;
        steps_ff <= pwdata[23:16];
        seek_recal_ff <= new_cmd == fdcic_pkg::CMD_RECAL;
      end else if (seek_done) begin
        seek_pend_ff <= 1'b1;
        // a seek that counts out is normal; only a recalibrate can miss home
        seek_bad_ff <= seek_recal_ff && !track0[seek_drv_ff];
      end else if (|busy_ff && !seek_pend_ff && tick && ms_left_ff == 8'h00) begin
        step_out <= 1'b1;
        steps_ff <= steps_ff - 8'h01;
      end
      if (accept && !is_inv && new_cmd == fdcic_pkg::CMD_SENSE_INT && seek_pend_ff) begin
        seek_pend_ff <= 1'b0;
        busy_ff <= 4'h0;
      end
    end
  end

  // ready change: a new change wins over the clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q_ff <= 4'h0;
      ready_chg_ff <= 4'h0;
    end else begin
      ready_q_ff <= drive_ready;
      ready_chg_ff <= ((accept && !is_inv && new_cmd == fdcic_pkg::CMD_SENSE_INT &&
        !seek_pend_ff) ? 4'h0 : ready_chg_ff) | (ready_q_ff ^ drive_ready);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_irq_ff <= 1'b0;
    end else if (xfer_done && is_xfer(cmd_ff)) begin
      data_irq_ff <= 1'b1;
    end else if (phase_ff == FDCIC_EXEC && pio && !data_acc) begin
      data_irq_ff <= 1'b1;
    end else if (data_acc) begin
      data_irq_ff <= 1'b0;
    end
  end

  // status byte latched at result entry for invalid and sense interrupt commands only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st0_ff <= 8'h00;
      result_ff <= 8'h00;
    end else if (is_inv) begin
      st0_ff <= fdcic_pkg::ST0_INVALID;
      result_ff <= fdcic_pkg::ST0_INVALID;
    end else if (accept && new_cmd == fdcic_pkg::CMD_SENSE_INT) begin
      st0_ff <= seek_pend_ff ? (seek_bad_ff ? fdcic_pkg::ST0_SEEK_BAD :
        fdcic_pkg::ST0_SEEK_OK) : fdcic_pkg::ST0_READY_CHG;
      result_ff <= seek_pend_ff ? (seek_bad_ff ? fdcic_pkg::ST0_SEEK_BAD :
        fdcic_pkg::ST0_SEEK_OK) : fdcic_pkg::ST0_READY_CHG;
    end else if (accept && new_cmd == fdcic_pkg::CMD_SENSE_DRV) begin
      result_ff <= drive_status;
    end else if (xfer_done) begin
      result_ff <= 8'h00;
    end
  end

  // level interrupt; invalid commands never reach any source
  assign irq = data_irq_ff || seek_pend_ff || |ready_chg_ff;

  wire [7:0] msr = {phase_ff != FDCIC_EXEC || pio, phase_ff == FDCIC_RESULT,
    phase_ff == FDCIC_EXEC && pio, 1'b0, busy_ff};

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        fdcic_pkg::ADDR_TIMER: prdata <= {16'h0000, timer_ff};
        fdcic_pkg::ADDR_DATA: prdata <= {24'h000000, result_ff};
        fdcic_pkg::ADDR_MSR: prdata <= {24'h000000, msr};
        fdcic_pkg::ADDR_STAT: prdata <= {24'h000000, st0_ff};
        fdcic_pkg::ADDR_EVENT: prdata <= {26'h0, seek_pend_ff, data_irq_ff, ready_chg_ff};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  sense_clears_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && !is_inv && new_cmd == fdcic_pkg::CMD_SENSE_INT && seek_pend_ff
    |=> !seek_pend_ff && busy_ff == 4'h0) else $error("sense did not clear seek");
  invalid_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    is_inv |=> result_ff == 8'h80 && phase_ff == FDCIC_RESULT && msr[7:6] == 2'b11)
    else $error("invalid command status wrong");
  invalid_noirq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    is_inv && !irq && (ready_q_ff == drive_ready) && !seek_done |=> !irq)
    else $error("invalid command raised irq");
  ready_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready_q_ff != drive_ready |=> irq) else $error("ready change missed");
  seek_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    seek_done |=> irq && seek_pend_ff) else $error("seek end no irq");
  result_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    xfer_done |=> phase_ff == FDCIC_RESULT && irq) else $error("result no irq");
  exec_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    phase_ff == FDCIC_EXEC && pio |-> msr[5]) else $error("exec flag low");
  force_inv_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && seek_pend_ff && new_cmd != fdcic_pkg::CMD_SENSE_INT |-> is_inv)
    else $error("unserviced seek not invalid");

  // command strobes shared by the checks below
  sequence seek_cmd_s;
    accept && !is_inv &&
      (new_cmd == fdcic_pkg::CMD_SEEK || new_cmd == fdcic_pkg::CMD_RECAL);
  endsequence
  sequence sense_seek_s;
    accept && !is_inv && new_cmd == fdcic_pkg::CMD_SENSE_INT && seek_pend_ff;
  endsequence
  sequence sense_ready_s;
    accept && !is_inv && new_cmd == fdcic_pkg::CMD_SENSE_INT && !seek_pend_ff &&
      |ready_chg_ff;
  endsequence
  sequence xfer_cmd_s;
    accept && !is_inv && is_xfer(new_cmd);
  endsequence
  // execution ends, result phase follows one edge later
  sequence xfer_end_s;
    xfer_done ##1 phase_ff == FDCIC_RESULT;
  endsequence

  busy_set_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    seek_cmd_s |=> busy_ff[$past(new_drv)])
    else $error("seek busy flag not set");
  head_load_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    xfer_cmd_s |=> head_load && phase_ff == FDCIC_EXEC)
    else $error("head not loaded for transfer");
  exec_clear_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    xfer_end_s |-> !msr[5])
    else $error("exec flag held into result");
  dma_flag_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    phase_ff == FDCIC_EXEC && !pio |-> !msr[5])
    else $error("exec flag raised in dma mode");
  pio_irq_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    phase_ff == FDCIC_EXEC && pio && !data_acc |=> irq)
    else $error("no transfer interrupt");
  data_clear_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    data_acc && !xfer_done |=> !data_irq_ff)
    else $error("data access kept interrupt");
  seek_cause_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    sense_seek_s |=> st0_ff[5] && !st0_ff[7])
    else $error("seek cause bits wrong");
  ready_cause_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    sense_ready_s |=> st0_ff == fdcic_pkg::ST0_READY_CHG)
    else $error("ready cause bits wrong");
  drive_stat_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    accept && !is_inv && new_cmd == fdcic_pkg::CMD_SENSE_DRV
    |=> result_ff == $past(drive_status))
    else $error("drive status not returned");
  invalid_st0_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    is_inv |=> st0_ff[7:6] == 2'b10)
    else $error("invalid code bits wrong");
  result_flags_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    phase_ff == FDCIC_RESULT |-> msr[7:6] == 2'b11)
    else $error("result phase flags wrong");
  step_pulse_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step_out |=> !step_out)
    else $error("step pulse too long");
  irq_hold_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    seek_pend_ff && !(accept && new_cmd == fdcic_pkg::CMD_SENSE_INT) |=> irq)
    else $error("pending seek lost interrupt");
  unload_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    head_load && phase_ff != FDCIC_EXEC && tick && ms_left_ff == 8'h01 && !accept
    |=> !head_load)
    else $error("head not unloaded");
  tick_wrap_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tick |=> ms_cnt_ff == 17'h00000)
    else $error("prescaler did not wrap");
endmodule

//--- rtl/fdcic_pkg.sv
package fdcic_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMER = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_MSR = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_EVENT = 8'h18;
  localparam logic [4:0] CMD_READ = 5'h06;
  localparam logic [4:0] CMD_READ_DEL = 5'h0C;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_WRITE_DEL = 5'h09;
  localparam logic [4:0] CMD_READ_TRK = 5'h02;
  localparam logic [4:0] CMD_READ_ID = 5'h0A;
  localparam logic [4:0] CMD_FORMAT = 5'h0D;
  localparam logic [4:0] CMD_SCAN_EQ = 5'h11;
  localparam logic [4:0] CMD_SCAN_LE = 5'h19;
  localparam logic [4:0] CMD_SCAN_HE = 5'h1D;
  localparam logic [4:0] CMD_SPECIFY = 5'h03;
  localparam logic [4:0] CMD_SENSE_DRV = 5'h04;
  localparam logic [4:0] CMD_SENSE_INT = 5'h08;
  localparam logic [4:0] CMD_SEEK = 5'h0F;
  localparam logic [4:0] CMD_RECAL = 5'h07;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] ST0_READY_CHG = 8'hC0;
  localparam logic [7:0] ST0_SEEK_OK = 8'h20;
  localparam logic [7:0] ST0_SEEK_BAD = 8'h60;
  localparam int MSR_BUSY_LSB = 0;
  localparam int MSR_EXEC_BIT = 5;
  localparam int MSR_DIR_BIT = 6;
  localparam int MSR_RQM_BIT = 7;
  localparam int TMR_SRT_LSB = 0;
  localparam int TMR_HUT_LSB = 4;
  localparam int TMR_HLT_LSB = 8;
  localparam int TMR_PIO_BIT = 15;
  localparam logic [15:0] TMR_RESET = 16'h0000;
  localparam int CLK_HZ = 125000000;
  localparam int NOMINAL_HZ = 16000000;
  localparam int MS_PER_STEP_SRT = 1;
  localparam int MS_PER_STEP_HUT = 16;
  localparam int MS_PER_STEP_HLT = 2;
  // one nominal ms, scaled to the 125 MHz core clock; ms ticks via prescaler
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam logic [16:0] MS_CYC = 17'(MS_CYCLES - 1);
endpackage

//--- dv/fdcic_drive_model.sv
`timescale 1ns/1ps
module fdcic_drive_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bench control
  input wire logic restart,
  input wire logic [7:0] lim,
  input wire logic [3:0] ready_req,
  // drive side
  input wire logic step_out,
  output logic [3:0] drive_ready,
  output logic [3:0] track0
);
  logic [7:0] steps_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      steps_ff <= 8'h00;
    end else if (restart) begin
      steps_ff <= 8'h00;
    end else if (step_out && steps_ff != 8'hFF) begin
      steps_ff <= steps_ff + 8'h01;
    end
  end
  // limit FF models a head that never finds home
  assign track0 = {4{steps_ff >= lim && lim != 8'hFF}};
  assign drive_ready = ready_req;
endmodule

//--- dv/fdcic_interrupt_cause_and_timing_setup_test.sv
`timescale 1ns/1ps
module fdcic_interrupt_cause_and_timing_setup_test;
  localparam int MS = 10;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, step_out, head_load, irq;
  logic restart;
  logic [7:0] paddr, drive_status, lim;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0] drive_ready, track0, ready_req;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  int mismatches, samples_checked, cyc, gap, gcnt;
  fdcic_core #(.MS_TICK(17'h00009)) fdcic_core_i (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_ready(drive_ready),
    .track0(track0), .drive_status(drive_status), .step_out(step_out),
    .head_load(head_load), .irq(irq));
  fdcic_drive_model fdcic_drive_model_i (.core_clk(core_clk), .rst_n(rst_n),
    .restart(restart), .lim(lim), .ready_req(ready_req), .step_out(step_out),
    .drive_ready(drive_ready), .track0(track0));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m);
    if (!w) begin
      eq.push_back(d);
      mq.push_back(m);
    end
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0000_0000;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, e, m);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    check(irq, 32'h0000_0001);
  endtask
  task automatic sense(input logic [7:0] e);
    wr(fdcic_pkg::ADDR_CMD, 32'(fdcic_pkg::CMD_SENSE_INT));
    @(negedge core_clk);
    check(irq, 32'h0000_0000);
    rd(fdcic_pkg::ADDR_STAT, 32'(e), 32'h0000_00FF);
    rd(fdcic_pkg::ADDR_DATA, 32'h0000_0000, 32'h0000_0000);
  endtask
  task automatic go(input logic [31:0] c, input logic [7:0] l);
    @(posedge core_clk);
    lim <= l;
    restart <= 1'b1;
    @(posedge core_clk);
    restart <= 1'b0;
    wr(fdcic_pkg::ADDR_CMD, c);
  endtask
  // read results are judged in the order they were requested
  always @(posedge core_clk) begin
    if (step_out === 1'b1) begin
      gap = gcnt;
      gcnt = 1;
    end else gcnt++;
    if (psel && penable && pready === 1'b1 && !pwrite)
      check(prdata & mq.pop_front(), eq.pop_front());
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; restart = 1'b0; lim = 8'hFF; ready_req = 4'h0;
    drive_status = 8'h00; rnd = 32'd72829; mismatches = 0; samples_checked = 0;
    cyc = 0; gcnt = 0; gap = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rnd = xs(rnd);
    drive_status <= rnd[7:0];
    wr(fdcic_pkg::ADDR_TIMER, 32'h0000_811F);
    rd(fdcic_pkg::ADDR_TIMER, 32'h0000_811F, 32'h0000_FFFF);
    wr(fdcic_pkg::ADDR_CMD, 32'h0000_001F);
    @(negedge core_clk);
    check(irq, 32'h0000_0000);
    rd(fdcic_pkg::ADDR_MSR, 32'h0000_00C0, 32'h0000_00C0);
    rd(fdcic_pkg::ADDR_STAT, 32'h0000_0080, 32'h0000_00FF);
    rd(fdcic_pkg::ADDR_DATA, 32'h0000_0000, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      wr(fdcic_pkg::ADDR_TIMER, 32'h0000_000F - 32'(i));
      go(32'h0003_000F, 8'hFF);
      rd(fdcic_pkg::ADDR_MSR, 32'h0000_0001, 32'h0000_0001);
      wait_irq();
      check(32'(gap), 32'((1 + i) * MS));
      sense(8'h20);
      rd(fdcic_pkg::ADDR_MSR, 32'h0000_0000, 32'h0000_0001);
    end
    // recalibrate that never finds home, then one that does
    for (int i = 0; i < 2; i++) begin
      go(32'h0002_0107, i ? 8'h01 : 8'hFF);
      wait_irq();
      sense(i ? 8'h20 : 8'h60);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      ready_req <= i ? 4'h0 : 4'h4;
      wait_irq();
      sense(8'hC0);
    end
    go(32'h0001_000F, 8'hFF);
    wait_irq();
    wr(fdcic_pkg::ADDR_CMD, 32'(fdcic_pkg::CMD_SENSE_DRV));
    rd(fdcic_pkg::ADDR_STAT, 32'h0000_0080, 32'h0000_00FF);
    rd(fdcic_pkg::ADDR_DATA, 32'h0000_0000, 32'h0000_0000);
    @(negedge core_clk);
    check(irq, 32'h0000_0001);
    sense(8'h20);
    wr(fdcic_pkg::ADDR_CMD, 32'(fdcic_pkg::CMD_SENSE_DRV));
    rd(fdcic_pkg::ADDR_DATA, 32'(drive_status), 32'h0000_00FF);
    // read command, programmed-io then dma
    for (int i = 0; i < 2; i++) begin
      wr(fdcic_pkg::ADDR_TIMER, i ? 32'h0000_011F : 32'h0000_811F);
      wr(fdcic_pkg::ADDR_CMD, 32'h0002_0000 | 32'(fdcic_pkg::CMD_READ));
      @(negedge core_clk);
      check(32'(head_load), 32'h0000_0001);
      rd(fdcic_pkg::ADDR_MSR, i ? 32'h0000_0000 : 32'h0000_00A0, 32'h0000_00E0);
      if (!i) begin
        wait_irq();
        repeat (2) begin
          wr(fdcic_pkg::ADDR_DATA, 32'h0000_0000);
          @(negedge core_clk);
          check(irq, 32'h0000_0000);
        end
      end else begin
        check(irq, 32'h0000_0000);
      end
      repeat (40) @(posedge core_clk);
      @(negedge core_clk);
      check(irq, 32'h0000_0001);
      rd(fdcic_pkg::ADDR_MSR, 32'h0000_00C0, 32'h0000_00E0);
      rd(fdcic_pkg::ADDR_DATA, 32'h0000_0000, 32'h0000_0000);
      @(negedge core_clk);
      check(irq, 32'h0000_0000);
      check(32'(head_load), 32'h0000_0001);
      repeat (200) @(posedge core_clk);
      @(negedge core_clk);
      check(32'(head_load), 32'h0000_0000);
    end
    rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
    repeat (4) @(posedge core_clk);
    conclude();
  end
endmodule
